// ==== psa_regs.vh ====
// Purpose: constants for the status and alarm block
// Assumes: command codes double as register offsets
// Notes:   included by every design file except the byte memory
`ifndef PSA_REGS_VH
`define PSA_REGS_VH
// command codes
`define PSA_CMD_CLEAR_FAULTS   8'h03
`define PSA_CMD_UV_WARN_LIMIT  8'h58
`define PSA_CMD_STATUS_BYTE    8'h78
`define PSA_CMD_STATUS_WORD    8'h79
`define PSA_CMD_STATUS_CML     8'h7E
`define PSA_CMD_FAN_SPEED      8'hD7
`define PSA_CMD_USER_BASE      8'hB0
`define PSA_CMD_USER_LAST      8'hB0
`define PSA_CMD_EEPROM_DATA    8'hB1
`define PSA_CMD_EEPROM_ADDR    8'hB2
`define PSA_CMD_USER_ADDR      8'hB3
// status byte bits
`define PSA_SB_OFF             6
`define PSA_SB_VOUT_OV         5
`define PSA_SB_IOUT_OC         4
`define PSA_SB_VIN_UV          3
`define PSA_SB_TEMP            2
`define PSA_SB_CML             1
// status word high byte bits
`define PSA_SW_INPUT           13
`define PSA_SW_PGOOD_N         11
// cml bits
`define PSA_CML_BAD_CMD        7
`define PSA_CML_BAD_DATA       6
// reset values and limits
`define PSA_UV_LIMIT_RST       16'h0000
`define PSA_FAN_RST            8'h00
`define PSA_FAN_MAX            8'h64
// memory sizes
`define PSA_USER_BYTES         96
`define PSA_EEPROM_BYTES       128
// led colour codes
`define PSA_LED_OFF            2'h0
`define PSA_LED_GREEN          2'h1
`define PSA_LED_AMBER          2'h2
`define PSA_LED_RED            2'h3
`endif

// ==== psa_mem.v ====
// Purpose: small byte memory with registered read data
// Assumes: one read or write per cycle
// Notes:   write protect blocks writes only
`timescale 1ns/100ps
module psa_mem #(
  parameter DEPTH = 96,
  parameter AW    = 7
) (
  // clock
  input  wire          clock,
  // access
  input  wire [AW-1:0] addr,
  input  wire          wr_en,
  input  wire          wr_protect,
  input  wire [7:0]    wr_data,
  output reg  [7:0]    rd_data_q
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en && !wr_protect && addr < DEPTH) begin
      mem[addr] <= wr_data;
    end
    if (addr < DEPTH) begin
      rd_data_q <= mem[addr];
    end else begin
      rd_data_q <= 8'h00;
    end
  end
endmodule // psa_mem

// ==== psa_led.v ====
// Purpose: alarm table decode to leds and monitoring levels
// Assumes: condition inputs are levels
// Notes:   registered outputs, reset shows normal operation
`timescale 1ns/100ps
`include "psa_regs.vh"
module psa_led (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // conditions
  input  wire       input_low,
  input  wire       output_overvoltage_shutdown,
  input  wire       overcurrent_shutdown,
  input  wire       remote_off,
  input  wire       temp_warning,
  input  wire       temp_shutdown,
  // indicators
  output reg  [1:0] input_indicator_led,
  output reg  [1:0] output_fault_led,
  output reg        fault_n_q,
  output reg        output_good_signal,
  output reg        input_good_q,
  output reg        temp_good_q
);
  wire out_lost = input_low | output_overvoltage_shutdown | overcurrent_shutdown |
                  remote_off | temp_shutdown;

  always @(posedge clock) begin
    if (!rst_n) begin
      input_indicator_led <= `PSA_LED_GREEN;
      output_fault_led    <= `PSA_LED_GREEN;
      fault_n_q           <= 1'b1;
      output_good_signal  <= 1'b1;
      input_good_q        <= 1'b1;
      temp_good_q         <= 1'b1;
    end else begin
      input_indicator_led <= input_low ? `PSA_LED_OFF : `PSA_LED_GREEN;
      // output-removing faults outrank the warning
      if (out_lost) begin
        output_fault_led <= `PSA_LED_RED;
      end else if (temp_warning) begin
        output_fault_led <= `PSA_LED_AMBER;
      end else begin
        output_fault_led <= `PSA_LED_GREEN;
      end
      fault_n_q          <= !out_lost;
      output_good_signal <= !out_lost;
      input_good_q       <= !input_low;
      temp_good_q        <= !(temp_warning | temp_shutdown);
    end
  end
endmodule // psa_led

// ==== psa_status.v ====
// Purpose: status word, fan speed, alert and alarm indication
// Assumes: a bus front end delivers decoded command transactions
// Notes:   one access per strobe; register reads answer next cycle, memory reads a cycle later
`timescale 1ns/100ps
`include "psa_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module psa_status (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // command port
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  input  wire        cmd_bad_data,
  output reg  [15:0] cmd_rdata_q,
  output reg         cmd_rvalid_q,
  // measurements and conditions
  input  wire [15:0] vin_measured,
  input  wire [7:0]  fan_min_percent,
  input  wire        input_low,
  input  wire        output_overvoltage_shutdown,
  input  wire        overcurrent_shutdown,
  input  wire        remote_off,
  input  wire        temp_warning,
  input  wire        temp_shutdown,
  input  wire        eeprom_wp,
  // fan
  output reg  [7:0]  fan_drive_q,
  // alert, open-drain: oe low drives the line low
  output wire        smbalert_out,
  output wire        smbalert_oe_n,
  // indicators
  output wire [1:0]  input_indicator_led,
  output wire [1:0]  output_fault_led,
  output wire        fault_n,
  output wire        output_good_signal,
  output wire        input_good,
  output wire        temp_good
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  function is_supported;
    input [7:0] c;
    begin
      case (c)
        `PSA_CMD_CLEAR_FAULTS, `PSA_CMD_UV_WARN_LIMIT, `PSA_CMD_STATUS_BYTE,
        `PSA_CMD_STATUS_WORD, `PSA_CMD_STATUS_CML, `PSA_CMD_FAN_SPEED,
        `PSA_CMD_EEPROM_DATA, `PSA_CMD_EEPROM_ADDR, `PSA_CMD_USER_ADDR,
        `PSA_CMD_USER_BASE: is_supported = 1'b1;
        default:            is_supported = 1'b0;
      endcase
    end
  endfunction

  wire wr       = cmd_valid & cmd_write;
  wire rd       = cmd_valid & ~cmd_write;
  wire bad_cmd  = cmd_valid & ~is_supported(cmd_code);
  // fan value above 100 percent is invalid data
  wire fan_bad  = wr & (cmd_code == `PSA_CMD_FAN_SPEED) & (cmd_wdata[7:0] > `PSA_FAN_MAX);
  wire bad_data = (cmd_valid & cmd_bad_data) | fan_bad;
  wire clear    = wr & (cmd_code == `PSA_CMD_CLEAR_FAULTS);

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] uv_limit_q;
  reg [7:0]  fan_req_q;
  reg [6:0]  user_addr_q;
  reg [6:0]  ee_addr_q;
  reg        uv_warn_q;
  reg        ov_q;
  reg        oc_q;
  reg        off_q;
  reg        temp_q;
  reg        cml_cmd_q;
  reg        cml_data_q;
  reg        input_q;

  wire uv_now = (vin_measured <= uv_limit_q);

  always @(posedge clock) begin
    if (!rst_n) begin
      uv_limit_q  <= `PSA_UV_LIMIT_RST;
      fan_req_q   <= `PSA_FAN_RST;
      user_addr_q <= 7'h00;
      ee_addr_q   <= 7'h00;
    end else if (wr) begin
      case (cmd_code)
        `PSA_CMD_UV_WARN_LIMIT: uv_limit_q  <= cmd_wdata;
        `PSA_CMD_FAN_SPEED:     if (!fan_bad) fan_req_q <= cmd_wdata[7:0];
        `PSA_CMD_USER_ADDR:     user_addr_q <= cmd_wdata[6:0];
        `PSA_CMD_EEPROM_ADDR:   ee_addr_q   <= cmd_wdata[6:0];
        default:                ;
      endcase
    end
  end

  // out of reset, never slower than the supply needed a cycle earlier, whatever was written
  always @(posedge clock) begin
    if (!rst_n) begin
      fan_drive_q <= `PSA_FAN_RST;
    end else begin
      fan_drive_q <= (fan_req_q < fan_min_percent) ? fan_min_percent : fan_req_q;
    end
  end

  // sticky flags: a live condition beats the clear, so it re-sets at once
  always @(posedge clock) begin
    if (!rst_n) begin
      uv_warn_q  <= 1'b0;
      ov_q       <= 1'b0;
      oc_q       <= 1'b0;
      off_q      <= 1'b0;
      temp_q     <= 1'b0;
      cml_cmd_q  <= 1'b0;
      cml_data_q <= 1'b0;
      input_q    <= 1'b0;
    end else begin
      uv_warn_q  <= uv_now | (uv_warn_q & ~clear);
      ov_q       <= output_overvoltage_shutdown | (ov_q & ~clear);
      oc_q       <= overcurrent_shutdown | (oc_q & ~clear);
      off_q      <= remote_off | input_low | (off_q & ~clear);
      temp_q     <= temp_warning | temp_shutdown | (temp_q & ~clear);
      cml_cmd_q  <= bad_cmd | (cml_cmd_q & ~clear);
      cml_data_q <= bad_data | (cml_data_q & ~clear);
      input_q    <= input_low | uv_now | (input_q & ~clear);
    end
  end

  wire [7:0] status_byte;
  assign status_byte = {1'b0, off_q, ov_q, oc_q, input_low & input_q, temp_q,
                        cml_cmd_q | cml_data_q, 1'b0};
  wire [15:0] status_word;
  assign status_word = {2'b00, input_q, 1'b0, off_q, 3'b000, status_byte};
  wire [7:0] status_cml = {cml_cmd_q, cml_data_q, 6'h00};

  // alert follows any sticky bit; cleared with them
  wire alert = |status_word | uv_warn_q;
  assign smbalert_out  = 1'b0;
  assign smbalert_oe_n = ~alert;

  ////////////////////////////////////////////////////////////////////////////////
  // memories
  wire [7:0] user_rd;
  wire [7:0] ee_rd;

  psa_mem #(.DEPTH(`PSA_USER_BYTES), .AW(7)) u_user (
    .clock      (clock),
    .addr       (user_addr_q),
    .wr_en      (wr & (cmd_code == `PSA_CMD_USER_BASE)),
    .wr_protect (1'b0),
    .wr_data    (cmd_wdata[7:0]),
    .rd_data_q  (user_rd)
  );

  psa_mem #(.DEPTH(`PSA_EEPROM_BYTES), .AW(7)) u_ident (
    .clock      (clock),
    .addr       (ee_addr_q),
    .wr_en      (wr & (cmd_code == `PSA_CMD_EEPROM_DATA)),
    .wr_protect (eeprom_wp),
    .wr_data    (cmd_wdata[7:0]),
    .rd_data_q  (ee_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read path; memory reads land one cycle after the address settles
  reg [7:0] rd_code_q;
  reg       rd_mem_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      cmd_rdata_q  <= 16'h0000;
      cmd_rvalid_q <= 1'b0;
      rd_code_q    <= 8'h00;
      rd_mem_q     <= 1'b0;
    end else begin
      rd_mem_q     <= rd & ((cmd_code == `PSA_CMD_USER_BASE) | (cmd_code == `PSA_CMD_EEPROM_DATA));
      rd_code_q    <= cmd_code;
      cmd_rvalid_q <= rd & ~((cmd_code == `PSA_CMD_USER_BASE) | (cmd_code == `PSA_CMD_EEPROM_DATA));
      if (rd_mem_q) begin
        cmd_rvalid_q <= 1'b1;
        cmd_rdata_q  <= {8'h00, (rd_code_q == `PSA_CMD_USER_BASE) ? user_rd : ee_rd};
      end else if (rd) begin
        case (cmd_code)
          `PSA_CMD_UV_WARN_LIMIT: cmd_rdata_q <= uv_limit_q;
          `PSA_CMD_STATUS_BYTE:   cmd_rdata_q <= {8'h00, status_byte};
          `PSA_CMD_STATUS_WORD:   cmd_rdata_q <= status_word;
          `PSA_CMD_STATUS_CML:    cmd_rdata_q <= {8'h00, status_cml};
          `PSA_CMD_FAN_SPEED:     cmd_rdata_q <= {8'h00, fan_drive_q};
          `PSA_CMD_USER_ADDR:     cmd_rdata_q <= {9'h000, user_addr_q};
          `PSA_CMD_EEPROM_ADDR:   cmd_rdata_q <= {9'h000, ee_addr_q};
          default:                cmd_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alarm indication
  psa_led u_led (
    .clock                       (clock),
    .rst_n                       (rst_n),
    .input_low                   (input_low),
    .output_overvoltage_shutdown (output_overvoltage_shutdown),
    .overcurrent_shutdown        (overcurrent_shutdown),
    .remote_off                  (remote_off),
    .temp_warning                (temp_warning),
    .temp_shutdown               (temp_shutdown),
    .input_indicator_led         (input_indicator_led),
    .output_fault_led            (output_fault_led),
    .fault_n_q                   (fault_n),
    .output_good_signal          (output_good_signal),
    .input_good_q                (input_good),
    .temp_good_q                 (temp_good)
  );
endmodule // psa_status

// ==== psa_status_properties.sv ====
// Purpose: port checks for the status and alarm block
// Assumes: sync active-low reset, one clock
// Notes:   bound to psa_status below
`timescale 1ns/100ps
`include "psa_regs.vh"
module psa_status_properties (
  // clock, reset and command port
  input wire        clock, input wire rst_n,
  input wire        cmd_valid, input wire cmd_write,
  input wire [7:0]  cmd_code, input wire [15:0] cmd_wdata,
  input wire [15:0] cmd_rdata_q, input wire cmd_rvalid_q,
  // conditions
  input wire [7:0]  fan_min_percent,
  input wire        input_low, input wire output_overvoltage_shutdown,
  input wire        overcurrent_shutdown, input wire remote_off,
  input wire        temp_warning, input wire temp_shutdown,
  // outputs
  input wire [7:0]  fan_drive_q, input wire smbalert_oe_n,
  input wire [1:0]  input_indicator_led, input wire [1:0] output_fault_led,
  input wire        fault_n, input wire output_good_signal,
  input wire        input_good, input wire temp_good
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  localparam [7:0] BAD_CODE = 8'hEE;
  wire       rd79 = cmd_valid && !cmd_write && cmd_code == `PSA_CMD_STATUS_WORD;
  wire       fan_wr = cmd_valid && cmd_write && cmd_code == `PSA_CMD_FAN_SPEED;
  wire       sd = output_overvoltage_shutdown | overcurrent_shutdown | remote_off;
  wire       live = sd | input_low | temp_warning | temp_shutdown;
  wire [1:0] il = input_indicator_led;
  wire [1:0] ol = output_fault_led;
  wire [3:0] mon = {fault_n, output_good_signal, input_good, temp_good};
  //////////////////////////////////////////////////////////////////////////////
  property p_word_answer; rd79 |=> cmd_rvalid_q; endproperty
  a_word_answer: assert property (p_word_answer) else $error("status word read not answered");
  property p_word_ov;
    rd79 && output_overvoltage_shutdown && $past(output_overvoltage_shutdown) && $past(rst_n)
      |=> cmd_rdata_q[`PSA_SB_VOUT_OV];
  endproperty
  a_word_ov: assert property (p_word_ov) else $error("status word low byte lacks overvoltage");
  property p_fan_floor; $past(rst_n) |-> fan_drive_q >= $past(fan_min_percent); endproperty
  a_fan_floor: assert property (p_fan_floor) else $error("fan below required minimum");
  property p_fan_set;
    fan_wr && cmd_wdata <= 16'h0064 && cmd_wdata[7:0] >= fan_min_percent ##1 !fan_wr && $stable(fan_min_percent)
      |=> fan_drive_q == $past(cmd_wdata[7:0], 2);
  endproperty
  a_fan_set: assert property (p_fan_set) else $error("fan write not applied");
  property p_bad_alert; cmd_valid && cmd_code == BAD_CODE |-> ##[1:2] !smbalert_oe_n; endproperty
  a_bad_alert: assert property (p_bad_alert) else $error("no alert on unsupported code");
  property p_live_alert; output_overvoltage_shutdown [*3] |-> !smbalert_oe_n; endproperty
  a_live_alert: assert property (p_live_alert) else $error("alert released under live fault");
  property p_normal; $past(rst_n) && !$past(live) |-> il == `PSA_LED_GREEN && ol == `PSA_LED_GREEN && &mon; endproperty
  a_normal: assert property (p_normal) else $error("normal indication wrong");
  property p_low;
    $past(rst_n) && $past(input_low) |-> il == `PSA_LED_OFF && ol == `PSA_LED_RED && mon[3:1] == 3'h0;
  endproperty
  a_low: assert property (p_low) else $error("low input indication wrong");
  property p_sd;
    $past(rst_n) && $past(sd) && !$past(input_low)
      |-> il == `PSA_LED_GREEN && ol == `PSA_LED_RED && mon[3:1] == 3'h1;
  endproperty
  a_sd: assert property (p_sd) else $error("shutdown indication wrong");
  property p_tw;
    $past(rst_n) && $past(temp_warning) && !$past(sd | input_low | temp_shutdown)
      |-> ol == `PSA_LED_AMBER && mon == 4'hE;
  endproperty
  a_tw: assert property (p_tw) else $error("temperature warning indication wrong");
  property p_ts;
    $past(rst_n) && $past(temp_shutdown) && !$past(input_low)
      |-> il == `PSA_LED_GREEN && ol == `PSA_LED_RED && mon == 4'h2;
  endproperty
  a_ts: assert property (p_ts) else $error("temperature shutdown indication wrong");
  c_word: cover property (rd79 ##1 cmd_rvalid_q);
  c_fan: cover property (fan_wr);
  c_amber: cover property (ol == `PSA_LED_AMBER);
endmodule // psa_status_properties
bind psa_status psa_status_properties i_props (.clock, .rst_n, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
  .cmd_rdata_q, .cmd_rvalid_q, .fan_min_percent, .input_low, .output_overvoltage_shutdown, .overcurrent_shutdown,
  .remote_off, .temp_warning, .temp_shutdown, .fan_drive_q, .smbalert_oe_n, .input_indicator_led,
  .output_fault_led, .fault_n, .output_good_signal, .input_good, .temp_good);

// ==== psa_host_model.sv ====
// Purpose: system host issuing command transactions
// Assumes: answers come within four edges
// Notes:   two idle cycles after every command keep memory reads legal
`timescale 1ns/100ps
module psa_host_model (
  // clock and answers
  input wire        clock,
  input wire [15:0] cmd_rdata_q,
  input wire        cmd_rvalid_q,
  // requests
  output reg        cmd_valid, output reg cmd_write, output reg cmd_bad_data,
  output reg [7:0]  cmd_code,
  output reg [15:0] cmd_wdata,
  output reg        timed_out
);
  initial begin
    cmd_valid = 1'b0; cmd_write = 1'b0; cmd_bad_data = 1'b0;
    cmd_code = 8'h00; cmd_wdata = 16'h0000; timed_out = 1'b0;
  end
  // fan percent goes as plain integer in the low byte
  // bad marks the transaction as carrying invalid data, as a front end would flag it
  task xfer(input wr, input bad, input [7:0] code, input [15:0] data, output [15:0] rd);
    integer n;
    begin
      @(posedge clock);
      cmd_valid <= 1'b1; cmd_write <= wr; cmd_bad_data <= bad; cmd_code <= code; cmd_wdata <= data;
      @(posedge clock);
      cmd_valid <= 1'b0;
      cmd_bad_data <= 1'b0;
      // stale data must not look valid after release
      cmd_wdata <= ~data;
      rd = 16'h0000;
      if (!wr) begin
        n = 0;
        do begin @(posedge clock); n = n + 1; end while (cmd_rvalid_q !== 1'b1 && n < 4);
        if (cmd_rvalid_q !== 1'b1) timed_out = 1'b1;
        rd = cmd_rdata_q;
      end
      repeat (2) @(posedge clock);
    end
  endtask
endmodule // psa_host_model

// ==== tb_top.sv ====
// Purpose: directed test of status, fan, alert, memories and alarm table
// Assumes: host model drives the command port
// Notes:   condition vector is {low, ov, oc, remote, temp warn, temp off}
`timescale 1ns/100ps
`include "psa_regs.vh"
module tb_top;
  reg         clock, rst_n, eeprom_wp;
  reg  [5:0]  cond;
  reg  [15:0] vin_measured, v;
  reg  [7:0]  fan_min_percent;
  wire        cmd_valid, cmd_write, cmd_bad_data, cmd_rvalid_q, smbalert_out, smbalert_oe_n;
  wire [7:0]  cmd_code, fan_drive_q;
  wire [15:0] cmd_wdata, cmd_rdata_q;
  wire [1:0]  il, ol;
  wire [3:0]  mon;
  integer     err_total, total_checks, i;
  localparam [111:0] TBL = {14'h005F, 14'h2031, 14'h1073, 14'h0873, 14'h026E, 14'h0172, 14'h0473, 14'h0372};
  psa_host_model i_host (.clock(clock), .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_bad_data(cmd_bad_data), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .timed_out());
  psa_status i_dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_bad_data(cmd_bad_data), .cmd_rdata_q(cmd_rdata_q),
    .cmd_rvalid_q(cmd_rvalid_q), .vin_measured(vin_measured), .fan_min_percent(fan_min_percent),
    .input_low(cond[5]), .output_overvoltage_shutdown(cond[4]), .overcurrent_shutdown(cond[3]),
    .remote_off(cond[2]), .temp_warning(cond[1]), .temp_shutdown(cond[0]), .eeprom_wp(eeprom_wp),
    .fan_drive_q(fan_drive_q), .smbalert_out(smbalert_out), .smbalert_oe_n(smbalert_oe_n),
    .input_indicator_led(il), .output_fault_led(ol), .fault_n(mon[3]), .output_good_signal(mon[2]),
    .input_good(mon[1]), .temp_good(mon[0]));
  //////////////////////////////////////////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task rd(input [7:0] code);
    begin
      i_host.xfer(1'b0, 1'b0, code, 16'h0000, v);
      if (i_host.timed_out) begin err_total = err_total + 1; conclude; end
    end
  endtask
  task wr(input [7:0] code, input [15:0] d);
    reg [15:0] unused;
    begin i_host.xfer(1'b1, 1'b0, code, d, unused); end
  endtask
  task setc(input [5:0] c);
    begin @(posedge clock); cond <= c; repeat (3) @(posedge clock); end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin clock = 1'b0; forever #2.5 clock = ~clock; end
  initial begin
    err_total = 0; total_checks = 0; rst_n = 1'b0; cond = 6'h00; eeprom_wp = 1'b0;
    vin_measured = 16'h0200; fan_min_percent = 8'h14;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(cmd_rvalid_q, 16'h0000);
    check({il, ol, mon}, 16'h005F);
    rd(`PSA_CMD_STATUS_WORD); check(v, 16'h0000);
    check({smbalert_out, smbalert_oe_n}, 16'h0001);
    wr(`PSA_CMD_FAN_SPEED, 16'h0032); check(fan_drive_q, 16'h0032);
    rd(`PSA_CMD_FAN_SPEED); check(v, 16'h0032);
    wr(`PSA_CMD_FAN_SPEED, 16'h0005); check(fan_drive_q, 16'h0014);
    wr(`PSA_CMD_FAN_SPEED, 16'h0064); check(fan_drive_q, 16'h0064);
    wr(`PSA_CMD_FAN_SPEED, 16'h0065); check(fan_drive_q, 16'h0064);
    rd(`PSA_CMD_STATUS_CML); check(v[`PSA_CML_BAD_DATA], 16'h0001);
    check(smbalert_oe_n, 16'h0000);
    wr(`PSA_CMD_CLEAR_FAULTS, 16'h0000); check(smbalert_oe_n, 16'h0001);
    wr(8'hEE, 16'h0000); rd(`PSA_CMD_STATUS_CML); check(v[`PSA_CML_BAD_CMD], 16'h0001);
    rd(`PSA_CMD_STATUS_BYTE); check(v[`PSA_SB_CML], 16'h0001);
    // invalid data flagged by the front end on a read-only code
    i_host.xfer(1'b1, 1'b1, `PSA_CMD_STATUS_WORD, 16'h0000, v);
    rd(`PSA_CMD_STATUS_CML); check(v[`PSA_CML_BAD_DATA], 16'h0001);
    wr(`PSA_CMD_CLEAR_FAULTS, 16'h0000); rd(`PSA_CMD_STATUS_CML); check(v, 16'h0000);
    wr(`PSA_CMD_UV_WARN_LIMIT, 16'h0200); rd(`PSA_CMD_UV_WARN_LIMIT); check(v, 16'h0200);
    rd(`PSA_CMD_STATUS_WORD); check(v[`PSA_SW_INPUT], 16'h0001);
    wr(`PSA_CMD_CLEAR_FAULTS, 16'h0000); check(smbalert_oe_n, 16'h0000);
    @(posedge clock); vin_measured <= 16'h0201;
    wr(`PSA_CMD_CLEAR_FAULTS, 16'h0000); check(smbalert_oe_n, 16'h0001);
    // last user byte, address set again before the read
    wr(`PSA_CMD_USER_ADDR, 16'h005F); wr(`PSA_CMD_USER_BASE, 16'h00A5); wr(`PSA_CMD_USER_ADDR, 16'h005F);
    rd(`PSA_CMD_USER_BASE); check(v[7:0], 16'h00A5);
    rd(`PSA_CMD_USER_ADDR); check(v, 16'h005F);
    wr(`PSA_CMD_EEPROM_ADDR, 16'h007F); wr(`PSA_CMD_EEPROM_DATA, 16'h005A);
    @(posedge clock); eeprom_wp <= 1'b1;
    wr(`PSA_CMD_EEPROM_DATA, 16'h00C3); wr(`PSA_CMD_EEPROM_ADDR, 16'h007F);
    rd(`PSA_CMD_EEPROM_DATA); check(v[7:0], 16'h005A);
    rd(`PSA_CMD_EEPROM_ADDR); check(v, 16'h007F);
    for (i = 7; i >= 0; i = i - 1) begin
      setc(TBL[i*14+8 +: 6]);
      check({il, ol, mon}, TBL[i*14 +: 8]);
    end
    setc(6'h10); rd(`PSA_CMD_STATUS_BYTE); i = v[7:0];
    rd(`PSA_CMD_STATUS_WORD); check(v[7:0], i[7:0]);
    check(v[`PSA_SB_VOUT_OV], 16'h0001);
    conclude;
  end
endmodule // tb_top
